// ---- include/bcache_pkg.sv ----
package bcache_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 34;
   localparam int DATA_W = 64;
   localparam int CHK_W = 8;
   localparam int IDX_W = 16;
   localparam int TAG_W = 9;

   // ==========================================================
   // address field positions
   localparam int QW_LSB = 3;
   localparam int HI_IDX_BIT = 15;
   localparam int SW_LSB = 18;
   localparam int TAG_LSB = 20;
   localparam int REGION_LSB = 32;
   localparam logic [1:0] REGION_CACHEABLE = 2'h0;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      SIZE_256K = 2'h0,
      SIZE_512K = 2'h1,
      SIZE_1M = 2'h2
   } size_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_LOOK = 7'h02,
      ST_CHECK = 7'h04,
      ST_WBACK = 7'h08,
      ST_FILL = 7'h10,
      ST_WRITE = 7'h20,
      ST_BYP = 7'h40
   } state_t;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } cpu_req_t;

   typedef struct packed {
      logic [CHK_W-1:0] check;
      logic [DATA_W-1:0] data;
   } line_t;

   typedef struct packed {
      logic [1:0] spare;
      logic valid;
      logic dirty;
      logic parity;
      logic [1:0] sw;
      logic [TAG_W-1:0] tag;
   } tag_entry_t;

   // ==========================================================
   // reset values
   localparam state_t STATE_RST = ST_IDLE;
   localparam logic [1:0] SIZE_RST = 2'h2;
   localparam logic EN_RST = 1'b0;

endpackage : bcache_pkg

// ---- src/bcache_ecc.sv ----
`timescale 1ns/1ps
module bcache_ecc (
   // encoder
   input wire logic [bcache_pkg::DATA_W-1:0] enc_data,
   output logic [bcache_pkg::CHK_W-1:0] enc_check,
   // decoder
   input wire bcache_pkg::line_t dec_line,
   output logic [bcache_pkg::DATA_W-1:0] dec_data,
   output logic dec_corr,
   output logic dec_uncorr
);

   // ==========================================================
   // hamming check over positions 1..71, bit 7 is overall parity
   always_comb begin
      int k;
      k = 0;
      enc_check = '0;
      for (int p = 1; p < 72; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (enc_data[k]) begin
               enc_check[6:0] = enc_check[6:0] ^ 7'(p);
            end
            k = k + 1;
         end
      end
      enc_check[7] = (^enc_data) ^ (^enc_check[6:0]);
   end

   // ==========================================================
   // syndrome, single correction and double detection
   always_comb begin
      int k;
      logic [6:0] syn;
      logic overall;
      k = 0;
      syn = dec_line.check[6:0];
      overall = (^dec_line.data) ^ (^dec_line.check);
      for (int p = 1; p < 72; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (dec_line.data[k]) begin
               syn = syn ^ 7'(p);
            end
            k = k + 1;
         end
      end
      dec_data = dec_line.data;
      k = 0;
      for (int p = 1; p < 72; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (overall && syn == 7'(p)) begin
               dec_data[k] = ~dec_line.data[k];
            end
            k = k + 1;
         end
      end
      dec_corr = overall;
      dec_uncorr = !overall && (syn != 7'h00);
   end

endmodule : bcache_ecc

// ---- src/bcache_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - low three address bits never index cache
// - address bit 15 drives high index output
// - bits 19:18 index or tag by size
// - one megabyte data from 128K byte parts
// - tag store 128K deep, one entry per block
// - read hit returns cache data, no DRAM
// - read miss fetches DRAM and allocates block
// - cacheable enabled write updates data and tag
// - bypass reads go straight to DRAM
// - bypass writes touch DRAM only
// - direct mapped, write-back, one quadword block
// - data carries ECC, tag carries parity
// - size 256K, 512K or 1M selects switching
module bcache_ctrl (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // static configuration pins
   input wire logic cache_en,
   input wire logic [1:0] cache_size,
   // processor request
   input wire logic req_valid,
   output logic req_ready,
   input wire bcache_pkg::cpu_req_t req,
   // response
   output logic rsp_valid,
   output logic [bcache_pkg::DATA_W-1:0] rsp_rdata,
   output logic rsp_err,
   // status
   output logic tag_perr,
   output logic ecc_corr,
   // cache sram arrays
   output logic [bcache_pkg::IDX_W-1:0] sram_idx,
   output logic sram_hi_idx,
   output logic sram_re,
   output logic sram_we,
   output bcache_pkg::line_t sram_wline,
   input wire bcache_pkg::line_t sram_rline,
   output bcache_pkg::tag_entry_t tag_wentry,
   input wire bcache_pkg::tag_entry_t tag_rentry,
   // dram
   output logic dram_req,
   output logic dram_we,
   output logic [bcache_pkg::ADDR_W-1:0] dram_addr,
   output logic [bcache_pkg::DATA_W-1:0] dram_wdata,
   input wire logic dram_ack,
   input wire logic [bcache_pkg::DATA_W-1:0] dram_rdata
);

   // ==========================================================
   // configuration synchronisers
   logic en_s1_q, en_s2_q;
   logic [1:0] size_s1_q, size_s2_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_s1_q <= bcache_pkg::EN_RST;
         en_s2_q <= bcache_pkg::EN_RST;
         size_s1_q <= bcache_pkg::SIZE_RST;
         size_s2_q <= bcache_pkg::SIZE_RST;
      end else begin
         en_s1_q <= cache_en;
         en_s2_q <= en_s1_q;
         size_s1_q <= cache_size;
         size_s2_q <= size_s1_q;
      end
   end

   // ==========================================================
   // ecc
   logic [bcache_pkg::DATA_W-1:0] line_data_d;
   logic [bcache_pkg::CHK_W-1:0] enc_check;
   logic [bcache_pkg::DATA_W-1:0] dec_data;
   logic dec_corr, dec_uncorr;

   bcache_ecc bcache_ecc_i (
      .enc_data(line_data_d),
      .enc_check(enc_check),
      .dec_line(sram_rline),
      .dec_data(dec_data),
      .dec_corr(dec_corr),
      .dec_uncorr(dec_uncorr)
   );

   // ==========================================================
   // controller state
   bcache_pkg::state_t state_q, state_d;
   bcache_pkg::cpu_req_t req_q, req_d;
   logic [bcache_pkg::IDX_W-1:0] idx_q, idx_d;
   logic hi_q, hi_d;
   bcache_pkg::line_t line_q;
   logic dram_req_q, dram_req_d, dram_we_q, dram_we_d;
   logic [bcache_pkg::ADDR_W-1:0] dram_addr_q, dram_addr_d;
   logic [bcache_pkg::DATA_W-1:0] dram_wdata_q, dram_wdata_d;
   logic rsp_valid_q, rsp_valid_d, rsp_err_q, rsp_err_d;
   logic [bcache_pkg::DATA_W-1:0] rsp_rdata_q, rsp_rdata_d;
   logic tag_perr_q, tag_perr_d, ecc_corr_q, ecc_corr_d;
   logic cacheable, perr, hit, victim_dirty;
   logic [1:0] sw_idx;
   logic [bcache_pkg::ADDR_W-1:0] victim_addr;

   assign cacheable = en_s2_q &&
      (req.addr[bcache_pkg::REGION_LSB+:2] == bcache_pkg::REGION_CACHEABLE);
   assign perr = ^tag_rentry;
   assign hit = tag_rentry.valid && !perr && tag_rentry.tag == req_q.addr[bcache_pkg::TAG_LSB+:bcache_pkg::TAG_W] &&
      tag_rentry.sw == req_q.addr[bcache_pkg::SW_LSB+:2];
   assign victim_dirty = tag_rentry.valid && tag_rentry.dirty && !perr && !hit;
   assign victim_addr = {5'h00, tag_rentry.tag, tag_rentry.sw, idx_q[13:12], hi_q, idx_q[11:0], 3'h0};

   always_comb begin
      unique case (bcache_pkg::size_t'(size_s2_q))
         bcache_pkg::SIZE_256K: sw_idx = 2'h0;
         bcache_pkg::SIZE_512K: sw_idx = {1'b0, req.addr[bcache_pkg::SW_LSB]};
         default: sw_idx = req.addr[bcache_pkg::SW_LSB+:2];
      endcase
   end

   always_comb begin
      state_d = state_q;
      req_d = req_q;
      idx_d = idx_q;
      hi_d = hi_q;
      line_data_d = line_q.data;
      dram_req_d = dram_req_q;
      dram_we_d = dram_we_q;
      dram_addr_d = dram_addr_q;
      dram_wdata_d = dram_wdata_q;
      rsp_valid_d = 1'b0;
      rsp_err_d = rsp_err_q;
      rsp_rdata_d = rsp_rdata_q;
      tag_perr_d = 1'b0;
      ecc_corr_d = 1'b0;
      unique case (state_q)
         bcache_pkg::ST_IDLE: begin
            if (req_valid) begin
               req_d = req;
               idx_d = {sw_idx, req.addr[17:16], req.addr[14:bcache_pkg::QW_LSB]};
               hi_d = req.addr[bcache_pkg::HI_IDX_BIT];
               line_data_d = req.wdata;
               if (cacheable) begin
                  state_d = bcache_pkg::ST_LOOK;
               end else begin
                  state_d = bcache_pkg::ST_BYP;
                  dram_req_d = 1'b1;
                  dram_we_d = req.write;
                  dram_addr_d = {req.addr[bcache_pkg::ADDR_W-1:bcache_pkg::QW_LSB], 3'h0};
                  dram_wdata_d = req.wdata;
               end
            end
         end
         bcache_pkg::ST_LOOK: begin
            state_d = bcache_pkg::ST_CHECK;
         end
         bcache_pkg::ST_CHECK: begin
            tag_perr_d = perr;
            if (hit && !req_q.write) begin
               state_d = bcache_pkg::ST_IDLE;
               rsp_valid_d = 1'b1;
               rsp_rdata_d = dec_data;
               rsp_err_d = dec_uncorr;
               ecc_corr_d = dec_corr;
            end else if (victim_dirty) begin
               state_d = bcache_pkg::ST_WBACK;
               dram_req_d = 1'b1;
               dram_we_d = 1'b1;
               dram_addr_d = victim_addr;
               dram_wdata_d = dec_data;
               ecc_corr_d = dec_corr;
            end else if (req_q.write) begin
               state_d = bcache_pkg::ST_WRITE;
            end else begin
               state_d = bcache_pkg::ST_FILL;
               dram_req_d = 1'b1;
               dram_we_d = 1'b0;
               dram_addr_d = {req_q.addr[bcache_pkg::ADDR_W-1:bcache_pkg::QW_LSB], 3'h0};
            end
         end
         bcache_pkg::ST_WBACK: begin
            if (dram_ack) begin
               if (req_q.write) begin
                  state_d = bcache_pkg::ST_WRITE;
                  dram_req_d = 1'b0;
               end else begin
                  state_d = bcache_pkg::ST_FILL;
                  dram_we_d = 1'b0;
                  dram_addr_d = {req_q.addr[bcache_pkg::ADDR_W-1:bcache_pkg::QW_LSB], 3'h0};
               end
            end
         end
         bcache_pkg::ST_FILL: begin
            if (dram_ack) begin
               state_d = bcache_pkg::ST_WRITE;
               dram_req_d = 1'b0;
               line_data_d = dram_rdata;
               rsp_valid_d = 1'b1;
               rsp_rdata_d = dram_rdata;
               rsp_err_d = 1'b0;
            end
         end
         bcache_pkg::ST_WRITE: begin
            state_d = bcache_pkg::ST_IDLE;
            if (req_q.write) begin
               rsp_valid_d = 1'b1;
               rsp_err_d = 1'b0;
            end
         end
         bcache_pkg::ST_BYP: begin
            if (dram_ack) begin
               state_d = bcache_pkg::ST_IDLE;
               dram_req_d = 1'b0;
               rsp_valid_d = 1'b1;
               rsp_rdata_d = req_q.write ? '0 : dram_rdata;
               rsp_err_d = 1'b0;
            end
         end
         default: begin
            state_d = bcache_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= bcache_pkg::STATE_RST;
         req_q <= '0;
         idx_q <= '0;
         hi_q <= 1'b0;
         line_q <= '0;
         dram_req_q <= 1'b0;
         dram_we_q <= 1'b0;
         dram_addr_q <= '0;
         dram_wdata_q <= '0;
         rsp_valid_q <= 1'b0;
         rsp_err_q <= 1'b0;
         rsp_rdata_q <= '0;
         tag_perr_q <= 1'b0;
         ecc_corr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
         idx_q <= idx_d;
         hi_q <= hi_d;
         line_q <= '{check: enc_check, data: line_data_d};
         dram_req_q <= dram_req_d;
         dram_we_q <= dram_we_d;
         dram_addr_q <= dram_addr_d;
         dram_wdata_q <= dram_wdata_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_err_q <= rsp_err_d;
         rsp_rdata_q <= rsp_rdata_d;
         tag_perr_q <= tag_perr_d;
         ecc_corr_q <= ecc_corr_d;
      end
   end

   // ==========================================================
   // tag entry and outputs
   always_comb begin
      tag_wentry = '0;
      tag_wentry.valid = 1'b1;
      tag_wentry.dirty = req_q.write;
      tag_wentry.sw = req_q.addr[bcache_pkg::SW_LSB+:2];
      tag_wentry.tag = req_q.addr[bcache_pkg::TAG_LSB+:bcache_pkg::TAG_W];
      tag_wentry.parity = ^{1'b1, req_q.write, req_q.addr[bcache_pkg::SW_LSB+:2],
         req_q.addr[bcache_pkg::TAG_LSB+:bcache_pkg::TAG_W]};
   end

   assign req_ready = (state_q == bcache_pkg::ST_IDLE);
   assign sram_idx = idx_q;
   assign sram_hi_idx = hi_q;
   assign sram_re = (state_q == bcache_pkg::ST_LOOK);
   assign sram_we = (state_q == bcache_pkg::ST_WRITE);
   assign sram_wline = line_q;
   assign dram_req = dram_req_q;
   assign dram_we = dram_we_q;
   assign dram_addr = dram_addr_q;
   assign dram_wdata = dram_wdata_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_rdata = rsp_rdata_q;
   assign rsp_err = rsp_err_q;
   assign tag_perr = tag_perr_q;
   assign ecc_corr = ecc_corr_q;

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   property p_qw_align;
      dram_req |-> dram_addr[2:0] == 3'h0;
   endproperty
   a_qw_align: assert property (p_qw_align) else $error("dram address not quadword aligned");

   property p_hi_index;
      state_q == bcache_pkg::ST_LOOK |-> sram_hi_idx == req_q.addr[bcache_pkg::HI_IDX_BIT];
   endproperty
   a_hi_index: assert property (p_hi_index) else $error("high index not address bit 15");

   property p_size_idx;
      state_q == bcache_pkg::ST_LOOK |->
         (size_s2_q == bcache_pkg::SIZE_256K && sram_idx[15:14] == 2'h0) ||
         (size_s2_q == bcache_pkg::SIZE_512K && sram_idx[15:14] == {1'b0, req_q.addr[18]}) ||
         (size_s2_q[1] && sram_idx[15:14] == req_q.addr[19:18]);
   endproperty
   a_size_idx: assert property (p_size_idx) else $error("switched index bits wrong for size");

   property p_read_hit;
      state_q == bcache_pkg::ST_CHECK && hit && !req_q.write |=>
         rsp_valid && !dram_req && rsp_rdata == $past(dec_data);
   endproperty
   a_read_hit: assert property (p_read_hit) else $error("read hit did not return cache data");

   property p_read_miss;
      state_q == bcache_pkg::ST_CHECK && !hit && !req_q.write && !victim_dirty |=>
         state_q == bcache_pkg::ST_FILL && dram_req && !dram_we && dram_addr == {req_q.addr[33:3], 3'h0};
   endproperty
   a_read_miss: assert property (p_read_miss) else $error("read miss did not fetch dram");

   property p_alloc;
      state_q == bcache_pkg::ST_FILL && dram_ack |=> sram_we && tag_wentry.valid && !tag_wentry.dirty &&
         sram_wline.data == $past(dram_rdata) ##1 state_q == bcache_pkg::ST_IDLE;
   endproperty
   a_alloc: assert property (p_alloc) else $error("fill did not allocate block");

   property p_write;
      state_q == bcache_pkg::ST_CHECK && req_q.write && !victim_dirty |=> sram_we && tag_wentry.dirty &&
         sram_wline.data == req_q.wdata;
   endproperty
   a_write: assert property (p_write) else $error("write did not update data and tag");

   property p_bypass_entry;
      req_valid && req_ready && !cacheable |=> state_q == bcache_pkg::ST_BYP && dram_req &&
         dram_we == $past(req.write);
   endproperty
   a_bypass_entry: assert property (p_bypass_entry) else $error("bypass did not go to dram");

   property p_bypass_no_cache;
      state_q == bcache_pkg::ST_BYP |-> !sram_re && !sram_we;
   endproperty
   a_bypass_no_cache: assert property (p_bypass_no_cache) else $error("bypass touched cache");

   property p_tag_parity;
      sram_we |-> (^tag_wentry) == 1'b0;
   endproperty
   a_tag_parity: assert property (p_tag_parity) else $error("tag parity wrong");

   property p_writeback;
      state_q == bcache_pkg::ST_CHECK && victim_dirty |=> state_q == bcache_pkg::ST_WBACK && dram_req &&
         dram_we && dram_addr == $past(victim_addr);
   endproperty
   a_writeback: assert property (p_writeback) else $error("dirty victim not written back");

   property p_perr_miss;
      state_q == bcache_pkg::ST_CHECK && perr |=> tag_perr && !rsp_valid;
   endproperty
   a_perr_miss: assert property (p_perr_miss) else $error("tag parity error not treated as miss");

   c_read_hit: cover property (state_q == bcache_pkg::ST_CHECK && hit && !req_q.write);
   c_writeback: cover property (state_q == bcache_pkg::ST_WBACK ##[1:20] state_q == bcache_pkg::ST_FILL);
   c_bypass: cover property (state_q == bcache_pkg::ST_BYP && dram_ack);
   c_perr: cover property (tag_perr);

endmodule : bcache_ctrl

// ---- verif/bcache_mem_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// sram arrays and dram behind the controller
module bcache_mem_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // cache sram arrays
   input wire logic [bcache_pkg::IDX_W-1:0] sram_idx,
   input wire logic sram_hi_idx,
   input wire logic sram_re,
   input wire logic sram_we,
   input wire bcache_pkg::line_t sram_wline,
   output bcache_pkg::line_t sram_rline,
   input wire bcache_pkg::tag_entry_t tag_wentry,
   output bcache_pkg::tag_entry_t tag_rentry,
   // dram
   input wire logic dram_req,
   input wire logic dram_we,
   input wire logic [bcache_pkg::ADDR_W-1:0] dram_addr,
   input wire logic [bcache_pkg::DATA_W-1:0] dram_wdata,
   output logic dram_ack,
   output logic [bcache_pkg::DATA_W-1:0] dram_rdata
);
   // 128K deep arrays, 72-bit data lines and 16-bit tag entries
   bcache_pkg::line_t dmem [0:131071];
   bcache_pkg::tag_entry_t tmem [0:131071];
   logic [63:0] dram [logic [33:0]];
   logic [71:0] dflip = 72'h0;
   logic [15:0] tflip = 16'h0;
   logic [16:0] last_a;
   int lat = 0;
   int cnt = 0;
   int rd_n = 0;
   int wr_n = 0;
   int re_n = 0;
   int we_n = 0;
   wire logic [16:0] a = {sram_hi_idx, sram_idx};

   initial begin
      sram_rline = 72'h0;
      tag_rentry = 16'h0;
      dram_rdata = 64'h0;
      for (int i = 0; i < 131072; i++) begin
         dmem[i] = 72'h0;
         tmem[i] = 16'h0;
      end
   end

   // ==========================================================
   // synchronous sram, outputs scrambled outside the read cycle
   always @(posedge core_clk) begin
      if (sram_we) begin
         dmem[a] <= sram_wline;
         tmem[a] <= tag_wentry;
         we_n++;
      end
      if (sram_re) begin
         sram_rline <= dmem[a] ^ dflip;
         tag_rentry <= tmem[a] ^ tflip;
         last_a <= a;
         re_n++;
      end else begin
         sram_rline <= ~sram_rline;
         tag_rentry <= ~tag_rentry;
      end
   end

   // ==========================================================
   // dram with selectable latency, one-cycle acknowledge
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dram_ack <= 1'b0;
         cnt = 0;
      end else if (dram_ack || !dram_req) begin
         dram_ack <= 1'b0;
         cnt = 0;
         dram_rdata <= ~dram_rdata;
      end else if (cnt < lat) begin
         cnt++;
         dram_rdata <= ~dram_rdata;
      end else begin
         dram_ack <= 1'b1;
         if (dram_we) begin
            dram[dram_addr] = dram_wdata;
            wr_n++;
         end else begin
            dram_rdata <= dram.exists(dram_addr) ? dram[dram_addr] : {30'h0, dram_addr};
            rd_n++;
         end
      end
   end
endmodule : bcache_mem_model

// ---- verif/test_backup_cache_control.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("[ERR] %0t got %0h want %0h", $time, (a), (e)); end end
// ==========================================================
// bench for the backup cache controller
module test_backup_cache_control;
   localparam logic [33:0] A = 34'h0_0010_8040;
   localparam logic [33:0] B = 34'h0_0020_8040;
   localparam logic [33:0] C = 34'h0_004c_8048;
   localparam logic [33:0] N = 34'h1_0000_2000;
   localparam logic [63:0] DA = 64'h1234_5678_9abc_def0;
   localparam logic [63:0] DB = 64'h0f0f_a5a5_3c3c_9696;
   localparam logic [63:0] DX = 64'hfedc_ba98_7654_3210;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cache_en = 1'b1;
   logic [1:0] cache_size = 2'h2;
   logic req_valid = 1'b0;
   bcache_pkg::cpu_req_t req = '0;
   logic req_ready, rsp_valid, rsp_err, tag_perr, ecc_corr, sram_hi_idx, sram_re, sram_we;
   logic dram_req, dram_we, dram_ack;
   logic [63:0] rsp_rdata, dram_wdata, dram_rdata;
   logic [15:0] sram_idx;
   logic [33:0] dram_addr;
   bcache_pkg::line_t sram_wline, sram_rline;
   bcache_pkg::tag_entry_t tag_wentry, tag_rentry;
   logic saw_perr, saw_corr;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   int rd0, wr0, re0, we0;
   logic [63:0] d;

   always #12.5 core_clk = ~core_clk;

   bcache_ctrl bcache_ctrl_i (.core_clk, .rst_n, .cache_en, .cache_size, .req_valid, .req_ready, .req,
      .rsp_valid, .rsp_rdata, .rsp_err, .tag_perr, .ecc_corr, .sram_idx, .sram_hi_idx, .sram_re, .sram_we,
      .sram_wline, .sram_rline, .tag_wentry, .tag_rentry, .dram_req, .dram_we, .dram_addr, .dram_wdata,
      .dram_ack, .dram_rdata);
   bcache_mem_model bcache_mem_model_i (.core_clk, .rst_n, .sram_idx, .sram_hi_idx, .sram_re, .sram_we,
      .sram_wline, .sram_rline, .tag_wentry, .tag_rentry, .dram_req, .dram_we, .dram_addr, .dram_wdata,
      .dram_ack, .dram_rdata);

   // ==========================================================
   // run limit
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // ==========================================================
   // shared request and counter helpers
   task automatic snap();
      rd0 = bcache_mem_model_i.rd_n;
      wr0 = bcache_mem_model_i.wr_n;
      re0 = bcache_mem_model_i.re_n;
      we0 = bcache_mem_model_i.we_n;
   endtask : snap

   task automatic xfer(input logic wr, input logic [33:0] ad, input logic [63:0] wd);
      int n = 0;
      saw_perr = 1'b0;
      saw_corr = 1'b0;
      snap();
      @(negedge core_clk);
      req_valid = 1'b1;
      req = '{write: wr, addr: ad, wdata: wd};
      while (req_ready !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 200) begin
         @(negedge core_clk);
         n++;
         saw_perr = saw_perr | (tag_perr === 1'b1);
         saw_corr = saw_corr | (ecc_corr === 1'b1);
      end
      `CHK(rsp_valid, 1'b1)
      d = rsp_rdata;
      while (req_ready !== 1'b1) @(negedge core_clk);
   endtask : xfer

   // ==========================================================
   // scenarios
   task automatic t_miss_hit();
      bcache_mem_model_i.dram[A] = DA;
      xfer(1'b0, A, 64'h0);
      `CHK(d, DA)
      `CHK(bcache_mem_model_i.rd_n - rd0, 1)
      `CHK(bcache_mem_model_i.we_n - we0, 1)
      `CHK(bcache_mem_model_i.last_a, {1'b1, A[19:16], A[14:3]})
      xfer(1'b0, A | 34'h5, 64'h0);
      `CHK(d, DA)
      `CHK(bcache_mem_model_i.rd_n - rd0, 0)
   endtask : t_miss_hit

   task automatic t_victim();
      bcache_mem_model_i.lat = 4;
      xfer(1'b1, B, DB);
      `CHK(bcache_mem_model_i.we_n - we0, 1)
      `CHK(bcache_mem_model_i.wr_n - wr0, 0)
      xfer(1'b0, B, 64'h0);
      `CHK(d, DB)
      `CHK(bcache_mem_model_i.rd_n - rd0, 0)
      xfer(1'b0, A, 64'h0);
      `CHK(bcache_mem_model_i.wr_n - wr0, 1)
      `CHK(bcache_mem_model_i.dram[B], DB)
      `CHK(d, DA)
      bcache_mem_model_i.lat = 0;
   endtask : t_victim

   task automatic t_bypass();
      xfer(1'b1, N, DX);
      `CHK(bcache_mem_model_i.dram[N], DX)
      `CHK(bcache_mem_model_i.we_n - we0, 0)
      xfer(1'b0, N, 64'h0);
      `CHK(d, DX)
      `CHK(bcache_mem_model_i.re_n - re0, 0)
      cache_en = 1'b0;
      repeat (4) @(negedge core_clk);
      xfer(1'b0, A, 64'h0);
      `CHK(bcache_mem_model_i.rd_n - rd0, 1)
      `CHK(bcache_mem_model_i.re_n - re0, 0)
      xfer(1'b1, A, DX);
      `CHK(bcache_mem_model_i.wr_n - wr0, 1)
      `CHK(bcache_mem_model_i.we_n - we0, 0)
      cache_en = 1'b1;
      repeat (4) @(negedge core_clk);
      xfer(1'b0, A, 64'h0);
      `CHK(d, DA)
   endtask : t_bypass

   task automatic t_errors();
      bcache_mem_model_i.dflip = 72'h20;
      xfer(1'b0, A, 64'h0);
      `CHK(d, DA)
      `CHK(saw_corr, 1'b1)
      `CHK(rsp_err, 1'b0)
      bcache_mem_model_i.dflip = 72'h0;
      bcache_mem_model_i.tflip = 16'h1;
      xfer(1'b0, A, 64'h0);
      bcache_mem_model_i.tflip = 16'h0;
      `CHK(saw_perr, 1'b1)
      `CHK(bcache_mem_model_i.rd_n - rd0, 1)
      `CHK(d, DX)
      bcache_mem_model_i.dflip = 72'h3;
      xfer(1'b0, A, 64'h0);
      bcache_mem_model_i.dflip = 72'h0;
      `CHK(rsp_err, 1'b1)
   endtask : t_errors

   task automatic t_sizes();
      for (int s = 0; s < 3; s++) begin
         cache_size = s[1:0];
         repeat (4) @(negedge core_clk);
         xfer(1'b0, C, 64'h0);
         `CHK(bcache_mem_model_i.last_a[16:14], {1'b1, s == 2, s != 0})
      end
      cache_size = 2'h0;
      repeat (4) @(negedge core_clk);
      xfer(1'b0, C, 64'h0);
      xfer(1'b0, C ^ 34'h4_0000, 64'h0);
      `CHK(bcache_mem_model_i.rd_n - rd0, 1)
      `CHK(d, {30'h0, C ^ 34'h4_0000})
      cache_size = 2'h2;
   endtask : t_sizes

   initial begin
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      t_miss_hit();
      t_victim();
      t_bypass();
      t_errors();
      t_sizes();
      conclude();
   end
endmodule : test_backup_cache_control
